// >>> verilog/vfp_pkg.sv
// Purpose: Constants and types of the vertex setup front end.
// Assumes: 8-bit sub-address over 24-bit payload.
// Notes:   Registers clear to zero.
`default_nettype none

package vfp_pkg;

  // ==========================================================
  // Command word layout
  // ==========================================================
  localparam logic [7:0] VFP_PARAM_TYPE = 8'h04;
  localparam int CMD_SUB_MSB = 31;
  localparam int CMD_SUB_LSB = 24;
  localparam int PAYLOAD_W = 24;

  // ==========================================================
  // Sub-addresses
  // ==========================================================
  localparam logic [7:0] SUB_FMT_CTRL = 8'h00;
  localparam logic [7:0] SUB_SLOT_FIRST = 8'h01;
  localparam logic [7:0] SUB_SLOT_LAST = 8'h05;
  localparam logic [7:0] SUB_PRIM_CYCLE = 8'h20;
  localparam logic [7:0] SUB_VB_BASE_LOW = 8'h21;
  localparam logic [7:0] SUB_VB_BASE_HIGH = 8'h22;
  localparam int SLOT_WORDS = 5;
  localparam int SLOTS = 15;

  // ==========================================================
  // Write masks; reserved bits are dropped
  // ==========================================================
  localparam logic [23:0] MASK_FMT_CTRL = 24'hFF_803F;
  localparam logic [23:0] MASK_SLOTS = 24'h3F_3F3F;
  localparam logic [23:0] MASK_PRIM_CYCLE = 24'hBF_FF03;
  localparam logic [23:0] MASK_BASE_LOW = 24'hFF_FFFF;
  localparam logic [23:0] MASK_BASE_HIGH = 24'h00_FFFF;
  localparam logic [23:0] REG_RESET = 24'h00_0000;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int XY_TEST_LSB = 22;
  localparam int Z_TEST_LSB = 20;
  localparam int W_TEST_LSB = 18;
  localparam int XY_SWAP_BIT = 17;
  localparam int VB_LOC_LSB = 15;
  localparam int VLEN_LSB = 0;
  localparam int SLOT_FIELD_SPACING = 8;
  localparam int CLIP_DIS_BIT = 23;
  localparam int EVEN_SEL_LSB = 16;
  localparam int MODE_LSB = 8;
  localparam int ODD_SEL_LSB = 8;
  localparam int FAST_BIT = 14;
  localparam int IDX_WIDTH_BIT = 1;
  localparam int VTX_SRC_BIT = 0;
  localparam int PITCH_LSB = 8;
  localparam int BASE_HIGH_LSB = 0;

  // Near clip adds at most two points
  localparam logic [1:0] CLIP_MAX_NEW_POINTS = 2'h2;

  // ==========================================================
  // Encodings
  // ==========================================================
  typedef enum logic [1:0] {
    NAN_OFF = 2'b00,
    NAN_DROP_PRIM = 2'b01
  } vfp_nan_mode_t;

  typedef enum logic [1:0] {
    SEL_NEW = 2'b00,
    SEL_PREV_A = 2'b01,
    SEL_PREV_B = 2'b10,
    SEL_PREV_C = 2'b11
  } vfp_sel_t;

  typedef enum logic [2:0] {
    ATTR_POSITION = 3'b000,
    ATTR_POINT_SIZE = 3'b001,
    ATTR_DIFFUSE = 3'b010,
    ATTR_SPECULAR = 3'b011,
    ATTR_FOG = 3'b100,
    ATTR_TEXTURE = 3'b101,
    ATTR_BACK_FACE = 3'b110,
    ATTR_RESERVED = 3'b111
  } vfp_attr_kind_t;

  localparam logic [5:0] CODE_POINT_SIZE = 6'h04;
  localparam logic [5:0] CODE_DIFFUSE = 6'h05;
  localparam logic [5:0] CODE_SPECULAR = 6'h06;
  localparam logic [5:0] CODE_FOG = 6'h07;
  localparam logic [5:0] CODE_TEX_FIRST = 6'h08;
  localparam logic [5:0] CODE_TEX_LAST = 6'h2F;
  localparam logic [5:0] CODE_BACK_FACE0 = 6'h31;
  localparam logic [5:0] CODE_BACK_FACE1 = 6'h32;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
    logic [31:0] w;
  } vfp_vertex_t;

  typedef struct packed {
    vfp_attr_kind_t kind;
    logic [3:0] texUnit;
    logic [1:0] component;
  } vfp_attr_info_t;

  typedef struct packed {
    logic [1:0] location;
    logic [7:0] pitch;
    logic [31:0] base;
    logic indexWide;
    logic indexSource;
  } vfp_vb_cfg_t;

endpackage : vfp_pkg

`default_nettype wire

// >>> verilog/vfp_nan_test.sv
// Purpose: Not-a-number test of components.
// Assumes: Single precision.
// Notes:   One per component group.
`default_nettype none
`timescale 1ns/1ps

module vfp_nan_test
  import vfp_pkg::*;
#(
  parameter int N = 1
) (
  input wire logic [1:0] mode,
  input wire logic [N*32-1:0] values,
  output logic dropPrim,
  output logic dropList
);

  logic [N-1:0] isNan;

  // Exponent all ones with nonzero fraction
  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign isNan[i] = (&values[i*32+30 -: 8]) & (|values[i*32+22 -: 23]);
  end

  // Mode 01 drops the primitive, 1x the whole list
  assign dropPrim = (|isNan) && (mode == NAN_DROP_PRIM);
  assign dropList = (|isNan) && mode[1];

endmodule : vfp_nan_test

`default_nettype wire

// >>> verilog/vfp_attr_decode.sv
// Purpose: Decodes one attribute code.
// Assumes: Six-bit codes.
// Notes:   30h and above 32h are reserved.
`default_nettype none
`timescale 1ns/1ps

module vfp_attr_decode
  import vfp_pkg::*;
(
  input wire logic [5:0] code,
  output vfp_attr_info_t info
);

  logic [5:0] texOff;
  logic isTex;

  assign isTex = (code >= CODE_TEX_FIRST) && (code <= CODE_TEX_LAST);
  assign texOff = code - CODE_TEX_FIRST;

  // Code classes
  assign info.kind = (code < CODE_POINT_SIZE) ? ATTR_POSITION :
    (code == CODE_POINT_SIZE) ? ATTR_POINT_SIZE :
    (code == CODE_DIFFUSE) ? ATTR_DIFFUSE :
    (code == CODE_SPECULAR) ? ATTR_SPECULAR :
    (code == CODE_FOG) ? ATTR_FOG :
    isTex ? ATTR_TEXTURE :
    ((code == CODE_BACK_FACE0) || (code == CODE_BACK_FACE1)) ?
    ATTR_BACK_FACE : ATTR_RESERVED;
  // Texture unit, and component S T R Q or X Y Z W
  assign info.texUnit = isTex ? texOff[5:2] : 4'h0;
  assign info.component = isTex ? texOff[1:0] :
    (code == CODE_BACK_FACE1) ? 2'h1 : code[1:0];

endmodule : vfp_attr_decode

`default_nettype wire

// >>> verilog/vfp_setup.sv
// Purpose: Vertex format and primitive setup front end.
//          Parameter words, tests, cycling, fetch.
// Assumes: Inputs synchronous to clk_sys.
// Notes:   No back-pressure.
`default_nettype none
`timescale 1ns/1ps

// Operation
// (R1) XY NaN: 00 off, 01 drop primitive, 1x drop list.
// (R2) Depth NaN: 00 off, 01 drop primitive, 1x drop list.
// (R3) W NaN: 00 off, 01 drop primitive, 1x drop list.
// (R4) Swap bit exchanges X and Y.
// (R5) Location 00 local, 01 dynamic, else reserved.
// (R6) Vertex length in words sets the stride.
// (R7) Slot words hold codes at 5:0, 13:8, 21:16.
// (R8) Codes: position, size, colours, fog, textures, back face.
// (R9) Clip bit 0 enables near clip of point-fill triangles.
// (R10) Clipping may add two interpolated points.
// (R11) Selector 00 new vertex, else reuse previous a, b, c.
// (R12) Mode 0 full cycle, x1xxxxxx fast, 10xxxxxx reserved.
// (R13) Fast: odd steps low six bits, even steps even set.
// (R14) Index width: 0 16-bit, 1 32-bit.
// (R15) Source: 0 inline vertices, 1 indexed fetch.
// (R16) 21h holds base address bits 23:0.
// (R17) Type 04h: 00h-1Fh format, 20h-3Fh buffer and primitive.
// (R18) 22h holds pitch in 15:8, base high byte in 7:0.
// (R19) Reserved bits ignored; reserved codes undefined.
module vfp_setup
  import vfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] parameterType,
  input wire logic [31:0] cmdWord,
  input wire logic [7:0] rdSubAddr,
  output logic [23:0] rdData,
  input wire logic vtxValid,
  input wire vfp_vertex_t vtxIn,
  input wire logic vtxLast,
  input wire logic isLine,
  input wire logic pointFill,
  input wire logic idxValid,
  input wire logic [31:0] idxIn,
  output logic fetchValid,
  output logic [31:0] fetchAddr,
  output logic primValid,
  output vfp_vertex_t primA,
  output vfp_vertex_t primB,
  output vfp_vertex_t primC,
  output logic primLine,
  output logic primListEnd,
  output logic nearClipEnable,
  output logic [1:0] clipNewPointsMax,
  output logic [5:0] vertexLengthWords,
  output vfp_vb_cfg_t vbCfg,
  output vfp_attr_info_t [SLOTS-1:0] attrInfo,
  output logic hasBackFace
);

  // ==========================================================
  // Parameter word registers
  // ==========================================================
  logic [23:0] fmtCtrl;
  logic [23:0] slotWord [SLOT_WORDS];
  logic [23:0] primCycle;
  logic [23:0] baseLow;
  logic [23:0] baseHighWord;

  logic [7:0] subAddr;
  logic [23:0] payload;
  logic typeHit;
  logic wrFmt;
  logic wrSlot;
  logic wrCycle;
  logic wrBaseLow;
  logic wrBaseHigh;
  logic [2:0] slotIdx;

  // Command decode for parameter type 04h
  assign subAddr = cmdWord[CMD_SUB_MSB:CMD_SUB_LSB];
  assign payload = cmdWord[PAYLOAD_W-1:0];
  assign typeHit = cmdValid && (parameterType == VFP_PARAM_TYPE); // [R17]
  assign wrFmt = typeHit && (subAddr == SUB_FMT_CTRL); // [R17]
  assign wrSlot = typeHit && (subAddr >= SUB_SLOT_FIRST) &&
    (subAddr <= SUB_SLOT_LAST); // [R7]
  assign wrCycle = typeHit && (subAddr == SUB_PRIM_CYCLE);
  assign wrBaseLow = typeHit && (subAddr == SUB_VB_BASE_LOW); // [R16]
  assign wrBaseHigh = typeHit && (subAddr == SUB_VB_BASE_HIGH); // [R18]
  assign slotIdx = 3'(subAddr - SUB_SLOT_FIRST);

  // Register writes, reserved bits masked off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fmtCtrl <= REG_RESET;
      primCycle <= REG_RESET;
      baseLow <= REG_RESET;
      baseHighWord <= REG_RESET;
    end else begin
      if (wrFmt) fmtCtrl <= payload & MASK_FMT_CTRL; // [R19]
      if (wrCycle) primCycle <= payload & MASK_PRIM_CYCLE; // [R19]
      if (wrBaseLow) baseLow <= payload & MASK_BASE_LOW; // [R16]
      if (wrBaseHigh) baseHighWord <= payload & MASK_BASE_HIGH; // [R18]
    end
  end

  // Attribute slot words
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOT_WORDS; i++) slotWord[i] <= REG_RESET;
    end else if (wrSlot) begin
      slotWord[slotIdx] <= payload & MASK_SLOTS; // [R7] [R19]
    end
  end

  // ==========================================================
  // Read back
  // ==========================================================
  logic [23:0] next_rdData;
  logic [7:0] rdSlotOff;

  assign rdSlotOff = rdSubAddr - SUB_SLOT_FIRST;
  // Unmapped sub-addresses read as zero
  assign next_rdData = (rdSubAddr == SUB_FMT_CTRL) ? fmtCtrl :
    ((rdSubAddr >= SUB_SLOT_FIRST) && (rdSubAddr <= SUB_SLOT_LAST)) ?
    slotWord[rdSlotOff[2:0]] :
    (rdSubAddr == SUB_PRIM_CYCLE) ? primCycle :
    (rdSubAddr == SUB_VB_BASE_LOW) ? baseLow :
    (rdSubAddr == SUB_VB_BASE_HIGH) ? baseHighWord : 24'h00_0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rdData <= REG_RESET;
    else rdData <= next_rdData;
  end

  // ==========================================================
  // Field extraction
  // ==========================================================
  logic [1:0] xyTestMode;
  logic [1:0] depthTestMode;
  logic [1:0] wTestMode;
  logic xySwap;
  logic clipDisable;
  logic [7:0] renderMode;
  logic [5:0] oddSel;
  logic [5:0] evenSel;
  logic fastCycle;

  assign xyTestMode = fmtCtrl[XY_TEST_LSB +: 2]; // [R1]
  assign depthTestMode = fmtCtrl[Z_TEST_LSB +: 2]; // [R2]
  assign wTestMode = fmtCtrl[W_TEST_LSB +: 2]; // [R3]
  assign xySwap = fmtCtrl[XY_SWAP_BIT]; // [R4]
  assign vertexLengthWords = fmtCtrl[VLEN_LSB +: 6]; // [R6]
  assign clipDisable = primCycle[CLIP_DIS_BIT];
  assign renderMode = primCycle[MODE_LSB +: 8];
  assign oddSel = primCycle[ODD_SEL_LSB +: 6]; // [R13]
  assign evenSel = primCycle[EVEN_SEL_LSB +: 6]; // [R13]
  // Bit 6 picks fast; 10xxxxxx runs full
  assign fastCycle = renderMode[FAST_BIT - MODE_LSB]; // [R12] [R19]

  // Buffer configuration
  assign vbCfg.location = fmtCtrl[VB_LOC_LSB +: 2]; // [R5]
  assign vbCfg.pitch = baseHighWord[PITCH_LSB +: 8]; // [R18]
  assign vbCfg.base = {baseHighWord[BASE_HIGH_LSB +: 8], baseLow}; // [R18]
  assign vbCfg.indexWide = primCycle[IDX_WIDTH_BIT]; // [R14]
  assign vbCfg.indexSource = primCycle[VTX_SRC_BIT]; // [R15]

  // Near clip for point-filled triangles only
  assign nearClipEnable = !clipDisable && pointFill && !isLine; // [R9]
  assign clipNewPointsMax = nearClipEnable ? CLIP_MAX_NEW_POINTS : 2'h0;
  // [R10] added points are interpolated downstream

  // ==========================================================
  // Attribute decode
  // ==========================================================
  logic [SLOTS-1:0] isBackFace;

  for (genvar s = 0; s < SLOTS; s++) begin : g_attr
    vfp_attr_decode u_dec (
      .code(slotWord[s / 3][(s % 3) * SLOT_FIELD_SPACING +: 6]), // [R7]
      .info(attrInfo[s]) // [R8]
    );
    assign isBackFace[s] = (attrInfo[s].kind == ATTR_BACK_FACE);
  end

  // Any slot carrying a back face colour
  assign hasBackFace = |isBackFace; // [R8]

  // ==========================================================
  // Index fetch address
  // ==========================================================
  logic [31:0] effIndex;
  logic [31:0] strideBytes;
  logic [31:0] next_fetchAddr;

  // 16-bit indices use only the low half
  assign effIndex = vbCfg.indexWide ? idxIn :
    {16'h0000, idxIn[15:0]}; // [R14]
  assign strideBytes = {24'h00_0000, vertexLengthWords, 2'b00}; // [R6]
  assign next_fetchAddr = vbCfg.base + 32'(effIndex * strideBytes);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fetchValid <= 1'b0;
      fetchAddr <= 32'h0000_0000;
    end else begin
      fetchValid <= idxValid && vbCfg.indexSource; // [R15]
      if (idxValid && vbCfg.indexSource) fetchAddr <= next_fetchAddr;
    end
  end

  // ==========================================================
  // Vertex intake: swap and position tests
  // ==========================================================
  vfp_vertex_t vtxSw;
  logic xyDropPrim;
  logic xyDropList;
  logic zDropPrim;
  logic zDropList;
  logic wDropPrim;
  logic wDropList;
  logic vtxDropPrim;
  logic vtxDropList;

  // Exchange X and Y when asked
  assign vtxSw.x = xySwap ? vtxIn.y : vtxIn.x; // [R4]
  assign vtxSw.y = xySwap ? vtxIn.x : vtxIn.y; // [R4]
  assign vtxSw.z = vtxIn.z;
  assign vtxSw.w = vtxIn.w;

  vfp_nan_test #(.N(2)) u_nan_xy (
    .mode(xyTestMode),
    .values({vtxIn.x, vtxIn.y}),
    .dropPrim(xyDropPrim), // [R1]
    .dropList(xyDropList) // [R1]
  );

  vfp_nan_test #(.N(1)) u_nan_z (
    .mode(depthTestMode),
    .values(vtxIn.z),
    .dropPrim(zDropPrim), // [R2]
    .dropList(zDropList) // [R2]
  );

  vfp_nan_test #(.N(1)) u_nan_w (
    .mode(wTestMode),
    .values(vtxIn.w),
    .dropPrim(wDropPrim), // [R3]
    .dropList(wDropList) // [R3]
  );

  assign vtxDropPrim = xyDropPrim | zDropPrim | wDropPrim;
  assign vtxDropList = xyDropList | zDropList | wDropList;

  // ==========================================================
  // Vertex cycling
  // ==========================================================
  vfp_vertex_t prevV [3];
  vfp_vertex_t curV [3];
  logic [2:0] gotMask;
  logic evenStep;
  logic primTaint;
  logic listTaint;
  logic [1:0] sel [3];
  logic [2:0] activeMask;
  logic [2:0] needMask;
  logic [2:0] openMask;
  logic [2:0] fillMask;
  logic complete;
  logic taintNow;
  logic listNow;
  vfp_vertex_t outV [3];

  // Selector set for this primitive
  assign sel[0] = !fastCycle ? SEL_NEW :
    evenStep ? evenSel[5:4] : oddSel[5:4]; // [R11] [R12] [R13]
  assign sel[1] = !fastCycle ? SEL_NEW :
    evenStep ? evenSel[3:2] : oddSel[3:2]; // [R11] [R13]
  assign sel[2] = !fastCycle ? SEL_NEW :
    evenStep ? evenSel[1:0] : oddSel[1:0]; // [R11] [R13]

  // Lines use a and b, triangles a, b and c
  assign activeMask = isLine ? 3'b011 : 3'b111; // [R12]
  assign needMask = activeMask & {sel[2] == SEL_NEW, sel[1] == SEL_NEW,
    sel[0] == SEL_NEW}; // [R11]
  assign openMask = needMask & ~gotMask;
  // Incoming vertex fills the lowest open slot
  assign fillMask = openMask & (~openMask + 3'b001);
  assign complete = vtxValid && ((openMask & ~fillMask) == 3'b000);
  assign taintNow = primTaint | vtxDropPrim;
  assign listNow = listTaint | vtxDropList;

  // Build a, b, c from new or reused vertices
  for (genvar k = 0; k < 3; k++) begin : g_out
    assign outV[k] = fillMask[k] ? vtxSw :
      (sel[k] == SEL_NEW) ? curV[k] :
      prevV[2'(sel[k] - 2'b01)]; // [R11]
  end

  // Slot capture and history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        curV[k] <= '0;
        prevV[k] <= '0;
      end
      gotMask <= 3'b000;
    end else if (vtxValid) begin
      for (int k = 0; k < 3; k++) begin
        if (fillMask[k]) curV[k] <= vtxSw;
        if (complete) prevV[k] <= outV[k]; // [R11]
      end
      gotMask <= (complete || vtxLast) ? 3'b000 : (gotMask | fillMask);
    end
  end

  // Step parity and drop flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evenStep <= 1'b0;
      primTaint <= 1'b0;
      listTaint <= 1'b0;
    end else if (vtxValid) begin
      // Each list starts on an odd step
      evenStep <= vtxLast ? 1'b0 : (complete ? !evenStep : evenStep); // [R13]
      primTaint <= (complete || vtxLast) ? 1'b0 : taintNow; // [R1] [R2] [R3]
      listTaint <= vtxLast ? 1'b0 : listNow; // [R1] [R2] [R3]
    end
  end

  // Primitive output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      primValid <= 1'b0;
      primA <= '0;
      primB <= '0;
      primC <= '0;
      primLine <= 1'b0;
      primListEnd <= 1'b0;
    end else begin
      primValid <= complete && !taintNow && !listNow; // [R1] [R2] [R3]
      primListEnd <= vtxValid && vtxLast;
      if (complete) begin
        primA <= outV[0];
        primB <= outV[1];
        primC <= outV[2];
        primLine <= isLine;
      end
    end
  end

endmodule : vfp_setup

`default_nettype wire

// >>> tb/vfp_setup_properties.sv
// Purpose: Port properties of vfp_setup.
// Assumes: One clock, rst active high.
// Notes:   Bound after the module.
`default_nettype none
`timescale 1ns/1ps

module vfp_setup_properties
  import vfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] parameterType,
  input wire logic [31:0] cmdWord,
  input wire logic isLine,
  input wire logic pointFill,
  input wire logic idxValid,
  input wire logic [31:0] idxIn,
  input wire logic fetchValid,
  input wire logic [31:0] fetchAddr,
  input wire logic nearClipEnable,
  input wire logic [1:0] clipNewPointsMax,
  input wire logic [5:0] vertexLengthWords,
  input wire vfp_vb_cfg_t vbCfg
);
  // =====
  // Helpers
  // Taken word, sub-address, expected fetch address
  wire logic take = cmdValid && parameterType == VFP_PARAM_TYPE;
  wire logic [7:0] sub = cmdWord[31:24];
  wire logic [31:0] idxEff = vbCfg.indexWide ? idxIn : {16'h0000, idxIn[15:0]};
  wire logic [31:0] addrExp = vbCfg.base +
    idxEff * {24'h00_0000, vertexLengthWords, 2'b00};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // =====
  // Properties
  chk_fetch_pulse: assert property (
    idxValid && vbCfg.indexSource |=> fetchValid)
    else $error("fetch strobe missing");
  chk_fetch_addr: assert property (
    idxValid && vbCfg.indexSource |=> fetchAddr == $past(addrExp))
    else $error("fetch address wrong");
  chk_base_low: assert property (
    take && sub == SUB_VB_BASE_LOW
    |=> vbCfg.base[23:0] == $past(cmdWord[23:0]))
    else $error("base low bytes wrong");
  chk_base_high: assert property (
    take && sub == SUB_VB_BASE_HIGH |=> vbCfg.pitch == $past(cmdWord[15:8])
    && vbCfg.base[31:24] == $past(cmdWord[7:0]))
    else $error("pitch or base high wrong");
  chk_format_len: assert property (
    take && sub == SUB_FMT_CTRL |=> vertexLengthWords == $past(cmdWord[5:0])
    && vbCfg.location == $past(cmdWord[16:15]))
    else $error("length or location wrong");
  chk_foreign_type: assert property (
    cmdValid && parameterType != VFP_PARAM_TYPE
    |=> $stable(vbCfg) && $stable(vertexLengthWords))
    else $error("foreign word taken");
  chk_clip_scope: assert property (
    nearClipEnable |-> pointFill && !isLine)
    else $error("clip enabled outside point fill");
  chk_clip_count: assert property (
    clipNewPointsMax == (nearClipEnable ? CLIP_MAX_NEW_POINTS : 2'h0))
    else $error("new point limit wrong");
endmodule : vfp_setup_properties

bind vfp_setup vfp_setup_properties vfp_setup_properties_inst (
  .clk_sys, .rst, .cmdValid, .parameterType, .cmdWord, .isLine,
  .pointFill, .idxValid, .idxIn, .fetchValid, .fetchAddr,
  .nearClipEnable, .clipNewPointsMax, .vertexLengthWords, .vbCfg);

`default_nettype wire

// >>> tb/vfp_cmd_source.sv
// Purpose: Driver command stream model.
// Assumes: Called at a falling edge.
// Notes:   Strobe held between words.
`default_nettype none
`timescale 1ns/1ps

module vfp_cmd_source
  import vfp_pkg::*;
(
  input wire logic clk_sys,
  output logic cmdValid,
  output logic [7:0] parameterType,
  output logic [31:0] cmdWord
);
  initial {cmdValid, parameterType, cmdWord} = '0;
  // One word held across one edge
  task automatic send(input logic [7:0] pt, input logic [7:0] sa,
                      input logic [23:0] d);
    cmdValid = 1'b1;
    parameterType = pt;
    cmdWord = {sa, d};
    @(negedge clk_sys);
  endtask : send
  // Release; word lines go stale
  task automatic idle();
    cmdValid = 1'b0;
    cmdWord = ~cmdWord;
    @(negedge clk_sys);
  endtask : idle
endmodule : vfp_cmd_source

`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for vfp_setup.
// Assumes: Inputs change at falling edges.
// Notes:   Outputs sampled one edge later.
`default_nettype none
`timescale 1ns/1ps

module testbench;
  import vfp_pkg::*;
  // =====
  // Signals
  logic clk_sys, rst, vtxValid, vtxLast, isLine, pointFill, idxValid;
  logic cmdValid, fetchValid, primValid, primLine, primListEnd;
  logic nearClipEnable, hasBackFace;
  logic [7:0] parameterType, rdSubAddr;
  logic [31:0] cmdWord, idxIn, fetchAddr;
  logic [23:0] rdData;
  logic [1:0] clipNewPointsMax;
  logic [5:0] vertexLengthWords;
  vfp_vertex_t vtxIn, primA, primB, primC;
  vfp_vb_cfg_t vbCfg;
  vfp_attr_info_t [SLOTS-1:0] attrInfo;
  int n_errors = 0, n_checks = 0, nPrim = 0, p0;
  localparam logic [31:0] QNAN = 32'h7FC0_0000;
  localparam logic [7:0] MSUB [7] = '{8'h00, 8'h01, 8'h05, 8'h20, 8'h21,
    8'h22, 8'h06};
  localparam logic [23:0] MMASK [7] = '{24'hFF_803F, 24'h3F_3F3F,
    24'h3F_3F3F, 24'hBF_FF03, 24'hFF_FFFF, 24'h00_FFFF, 24'h00_0000};
  localparam logic [5:0] CODE [11] = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h07, 6'h08, 6'h2F, 6'h30, 6'h31, 6'h32};
  localparam logic [2:0] KIND [11] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
    3'h5, 3'h5, 3'h7, 3'h6, 3'h6};

  vfp_cmd_source vfp_cmd_source_inst (.clk_sys, .cmdValid, .parameterType,
    .cmdWord);
  vfp_setup vfp_setup_inst (.clk_sys, .rst, .cmdValid, .parameterType,
    .cmdWord, .rdSubAddr, .rdData, .vtxValid, .vtxIn, .vtxLast, .isLine,
    .pointFill, .idxValid, .idxIn, .fetchValid, .fetchAddr, .primValid,
    .primA, .primB, .primC, .primLine, .primListEnd, .nearClipEnable,
    .clipNewPointsMax, .vertexLengthWords, .vbCfg, .attrInfo,
    .hasBackFace);

  // Clock, primitive count, limit
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (primValid === 1'b1) nPrim <= nPrim + 1;
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end

  // =====
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] sa, input logic [23:0] d);
    vfp_cmd_source_inst.send(VFP_PARAM_TYPE, sa, d);
    vfp_cmd_source_inst.idle();
  endtask : wr
  task automatic rd(input logic [7:0] sa, input logic [23:0] exp);
    rdSubAddr = sa;
    @(negedge clk_sys);
    check("rdData", rdData, exp);
  endtask : rd
  function automatic vfp_vertex_t mkv(input logic [7:0] n, input int k);
    vfp_vertex_t v;
    v = {24'h40_0001, n, 24'h40_0002, n, 24'h40_0003, n, 24'h40_0004, n};
    if (k == 0) v.x = QNAN;
    if (k == 1) v.z = QNAN;
    if (k == 2) v.w = QNAN;
    return v;
  endfunction : mkv
  task automatic vtx(input logic [7:0] n, input logic last, input int k);
    vtxValid = 1'b1;
    vtxIn = mkv(n, k);
    vtxLast = last;
    @(negedge clk_sys);
  endtask : vtx
  task automatic vidle();
    vtxValid = 1'b0;
    vtxLast = 1'b0;
    vtxIn = ~vtxIn;
    @(negedge clk_sys);
  endtask : vidle
  task automatic tri3(input logic [7:0] b, input int k, input logic last);
    vtx(b, 1'b0, -1);
    vtx(b + 8'd1, 1'b0, k);
    vtx(b + 8'd2, last, -1);
  endtask : tri3
  task automatic chk_prim(input logic [7:0] a, b, c);
    check("primValid", primValid, 1'b1);
    check("primA", primA.w, {24'h40_0004, a});
    check("primB", primB.w, {24'h40_0004, b});
    check("primC", primC.w, {24'h40_0004, c});
  endtask : chk_prim
  task automatic idx(input logic [31:0] i, input logic v,
                     input logic [31:0] a);
    idxValid = 1'b1;
    idxIn = i;
    @(negedge clk_sys);
    idxValid = 1'b0;
    check("fetchValid", fetchValid, v);
    check("fetchAddr", fetchAddr, a);
  endtask : idx

  // =====
  // Main sequence
  initial begin
    {rst, vtxValid, vtxLast, isLine, pointFill, idxValid} = 6'b10_0000;
    {rdSubAddr, idxIn} = '0;
    vtxIn = mkv(8'h00, -1);
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(MSUB[i], 24'h00_0000);
      wr(MSUB[i], 24'hFF_FFFF);
      rd(MSUB[i], MMASK[i]);
    end
    vfp_cmd_source_inst.send(8'h03, 8'h00, 24'h00_0000);
    vfp_cmd_source_inst.idle();
    rd(8'h00, 24'hFF_803F);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h22, 24'h00_0000);
    $display("Registers done");
    for (int i = 0; i < 11; i++) begin
      wr(8'h01, {10'h000, CODE[i], 8'h00});
      check("kind", attrInfo[1].kind, KIND[i]);
      check("backFace", hasBackFace, KIND[i] == 3'h6);
    end
    wr(8'h04, 24'h2F_0800);
    check("texA", {attrInfo[10].texUnit, attrInfo[10].component},
          6'h00);
    check("texJ", {attrInfo[11].texUnit, attrInfo[11].component},
          6'h27);
    $display("Attributes done");
    wr(8'h00, 24'h00_8005);
    vfp_cmd_source_inst.send(VFP_PARAM_TYPE, 8'h21, 24'h12_3450);
    vfp_cmd_source_inst.send(VFP_PARAM_TYPE, 8'h22, 24'h00_10AB);
    vfp_cmd_source_inst.idle();
    check("pitch", vbCfg.pitch, 8'h10);
    wr(8'h20, 24'h00_0001);
    idx(32'h0001_0003, 1'b1, 32'hAB12_348C);
    wr(8'h20, 24'h00_0003);
    idx(32'h0001_0003, 1'b1, 32'hAB26_348C);
    wr(8'h20, 24'h00_0000);
    idx(32'h0001_0003, 1'b0, 32'hAB26_348C);
    $display("Index fetch done");
    wr(8'h00, 24'h02_8005);
    tri3(8'd1, -1, 1'b1);
    check("swap", primA.x, {24'h40_0002, 8'd1});
    chk_prim(8'd1, 8'd2, 8'd3);
    check("listEnd", primListEnd, 1'b1);
    isLine = 1'b1;
    vtx(8'd4, 1'b0, -1);
    vtx(8'd5, 1'b1, -1);
    check("line", {primValid, primLine, primA.w[7:0], primB.w[7:0]},
          18'h3_0405);
    isLine = 1'b0;
    vidle();
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, (24'h40_0000 >> (2 * k)) | 24'h00_8005);
      p0 = nPrim;
      tri3(8'd20, k, 1'b0);
      tri3(8'd23, -1, 1'b1);
      vidle();
      check("dropPrim", nPrim - p0, 1);
      wr(8'h00, (24'h80_0000 >> (2 * k)) | 24'h00_8005);
      p0 = nPrim;
      tri3(8'd26, k, 1'b0);
      tri3(8'd29, -1, 1'b1);
      tri3(8'd32, -1, 1'b1);
      vidle();
      check("dropList", nPrim - p0, 1);
    end
    $display("Vertex tests done");
    wr(8'h00, 24'h00_8005);
    tri3(8'd10, -1, 1'b1);
    vidle();
    wr(8'h20, 24'h2C_5C00);
    vtx(8'd13, 1'b0, -1);
    chk_prim(8'd10, 8'd12, 8'd13);
    vtx(8'd14, 1'b0, -1);
    chk_prim(8'd12, 8'd13, 8'd14);
    vtx(8'd15, 1'b1, -1);
    chk_prim(8'd12, 8'd14, 8'd15);
    vidle();
    $display("Fast cycle done");
    pointFill = 1'b1;
    wr(8'h20, 24'h00_0000);
    check("clipOn", {nearClipEnable, clipNewPointsMax}, 3'b110);
    wr(8'h20, 24'h80_0000);
    check("clipOff", {nearClipEnable, clipNewPointsMax}, 3'b000);
    $display("Clipping done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
